// File: shared/esr_consts.svh
// constants for the esd count and sgmii negotiation register bank
// assumes a 40 MHz system clock and 16-bit register data
`ifndef ESR_CONSTS_SVH
`define ESR_CONSTS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ESR_ADDR_W 11
`define ESR_DATA_W 16
`define ESR_OFF_ESD_COUNTS 11'h448
`define ESR_OFF_IRQ_STATUS 11'h44A
`define ESR_OFF_IRQ_MASK 11'h44B
`define ESR_OFF_TIMER_CFG 11'h456
`define ESR_OFF_AN_STATUS 11'h459

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define ESR_CNT_W 6
`define ESR_XMII_CNT_LSB 8
`define ESR_MDI_CNT_LSB 0
`define ESR_TIMER_LSB 12
`define ESR_TIMER_RST 2'h1
`define ESR_TIMER_RSVD 12'h008
`define ESR_PAGE_BIT 1
`define ESR_DONE_BIT 0
`define ESR_IRQ_W 4
`define ESR_IRQ_XMII 0
`define ESR_IRQ_MDI 1
`define ESR_IRQ_PAGE 2
`define ESR_IRQ_DONE 3

// ------------------------------------------------------------
// negotiation timer lengths
// ------------------------------------------------------------
`define ESR_CLK_KHZ 40000
`define ESR_T_1P6MS_NS 1600000
`define ESR_T_2US_NS 2000
`define ESR_T_800US_NS 800000
`define ESR_T_11MS_NS 11000000
`define ESR_TMR_W 19
`define ESR_NS_PER_MS 1000000

`endif

// File: shared/esr_pkg.sv
// types shared by the esd count and sgmii negotiation register bank
// assumes the constants header is on the include path
`include "esr_consts.svh"

package esr_pkg;

  // register port request, one cycle per access
  typedef struct packed {
    logic [`ESR_ADDR_W-1:0] addr;
    logic [`ESR_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } esr_bus_req_s;

  // negotiation timer choices in field order
  typedef enum logic [1:0] {
    ESR_TMR_1P6MS,
    ESR_TMR_2US,
    ESR_TMR_800US,
    ESR_TMR_11MS
  } esr_an_timer_e;

endpackage : esr_pkg

// File: rtl/esr_regs.sv
// esd event counters and sgmii negotiation timer and status registers
// assumes esd sense lines arrive asynchronously from the pad sensors and
// negotiation signals come from logic on i_clk_sys
//
// Summary of operation
// - mac-side esd detections increment upper counter
// - line-side esd detections increment lower counter
// - no dead-time; every detection edge counts until the counter saturates at 63
// - counters clear only at power-up
// - two-bit field selects negotiation timer length
// - page-received bit set by arriving page
// - complete bit shows negotiation finished
`timescale 1ns/1ps
`include "esr_consts.svh"

module esr_regs #(
  // whole microseconds times clock megahertz keeps the product inside 32 bits
  parameter int unsigned TMR_1P6MS_CYC =
    `ESR_T_1P6MS_NS / 1000 * (`ESR_CLK_KHZ / 1000),
  parameter int unsigned TMR_800US_CYC =
    `ESR_T_800US_NS * (`ESR_CLK_KHZ / 1000) / 1000,
  parameter int unsigned TMR_11MS_CYC =
    `ESR_T_11MS_NS / `ESR_NS_PER_MS * `ESR_CLK_KHZ
) (
  // clock and resets
  input logic i_clk_sys,
  input logic i_reset,
  input logic i_power_on_reset,
  // register port
  input esr_pkg::esr_bus_req_s i_bus,
  output logic [`ESR_DATA_W-1:0] o_rdata,
  // esd sensors, asynchronous
  input logic i_esd_mac_side,
  input logic i_esd_line_side,
  // negotiation engine
  input logic i_an_page_rx,
  input logic i_an_complete,
  output logic [1:0] o_an_timer_sel,
  output logic [`ESR_TMR_W-1:0] o_an_timer_cycles,
  // interrupt
  output logic o_irq
);
  import esr_pkg::*;

  // ------------------------------------------------------------
  // constants and elaboration checks
  // ------------------------------------------------------------
  localparam int unsigned TMR_2US_CYC =
    `ESR_T_2US_NS * (`ESR_CLK_KHZ / 1000) / 1000;
  localparam logic [`ESR_CNT_W-1:0] CNT_MAX = '1;

  initial begin
    if (TMR_1P6MS_CYC < 1 || TMR_1P6MS_CYC >= (1 << `ESR_TMR_W))
      $error("timer count for 1.6 ms out of range");
    if (TMR_800US_CYC < 1 || TMR_800US_CYC >= (1 << `ESR_TMR_W))
      $error("timer count for 800 us out of range");
    if (TMR_11MS_CYC < 1 || TMR_11MS_CYC >= (1 << `ESR_TMR_W))
      $error("timer count for 11 ms out of range");
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic hit_cnt, hit_sts, hit_msk, hit_tmr, hit_an;
  logic [`ESR_CNT_W-1:0] cnt_q [2];

  always_comb begin
    hit_cnt = 1'b0;
    hit_sts = 1'b0;
    hit_msk = 1'b0;
    hit_tmr = 1'b0;
    hit_an = 1'b0;
    if (i_bus.addr == `ESR_OFF_ESD_COUNTS) begin
      hit_cnt = 1'b1;
    end else if (i_bus.addr == `ESR_OFF_IRQ_STATUS) begin
      hit_sts = 1'b1;
    end else if (i_bus.addr == `ESR_OFF_IRQ_MASK) begin
      hit_msk = 1'b1;
    end else if (i_bus.addr == `ESR_OFF_TIMER_CFG) begin
      hit_tmr = 1'b1;
    end else if (i_bus.addr == `ESR_OFF_AN_STATUS) begin
      hit_an = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // esd sense synchronisers and edge detect
  // ------------------------------------------------------------
  logic [1:0] esd_in;
  logic [1:0] sync1_q, sync1_d;
  logic [1:0] sync2_q, sync2_d;
  logic [1:0] esd_dly_q, esd_dly_d;
  logic [1:0] esd_edge;

  assign esd_in = {i_esd_line_side, i_esd_mac_side};

  // edge taken from the second stage only; first stage feeds nothing else
  always_comb begin
    sync1_d = esd_in;
    sync2_d = sync1_q;
    esd_dly_d = sync2_q;
    esd_edge = sync2_q & ~esd_dly_q;
  end

  // synchronisers are free running so no reset is needed for safety
  always_ff @(posedge i_clk_sys) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
    esd_dly_q <= esd_dly_d;
  end

  // ------------------------------------------------------------
  // esd event counters, index 0 mac side, index 1 line side
  // ------------------------------------------------------------
  logic [`ESR_CNT_W-1:0] cnt_d [2];

  for (genvar g = 0; g < 2; g++) begin : g_cnt
    always_comb begin
      cnt_d[g] = cnt_q[g];
      if (esd_edge[g] && cnt_q[g] != CNT_MAX)
        cnt_d[g] = cnt_q[g] + `ESR_CNT_W'(1);
    end

    // power-up clear only
    // hardware reset is deliberately absent so history survives it
    always_ff @(posedge i_clk_sys) begin
      if (i_power_on_reset) begin
        cnt_q[g] <= '0;
      end else begin
        cnt_q[g] <= cnt_d[g];
      end
    end
  end

  // ------------------------------------------------------------
  // negotiation timer select and status
  // ------------------------------------------------------------
  logic [1:0] tsel_q, tsel_d;
  logic [`ESR_TMR_W-1:0] tcyc_q, tcyc_d;
  logic page_q, page_d;
  logic done_q, done_d;
  logic done_prev_q, done_prev_d;
  logic rd_an;

  assign rd_an = i_bus.rd && hit_an;

  always_comb begin
    tsel_d = tsel_q;
    if (i_bus.wr && hit_tmr)
      tsel_d = i_bus.wdata[`ESR_TIMER_LSB +: 2];
    case (esr_an_timer_e'(tsel_q))
      ESR_TMR_1P6MS: tcyc_d = `ESR_TMR_W'(TMR_1P6MS_CYC);
      ESR_TMR_2US: tcyc_d = `ESR_TMR_W'(TMR_2US_CYC);
      ESR_TMR_800US: tcyc_d = `ESR_TMR_W'(TMR_800US_CYC);
      default: tcyc_d = `ESR_TMR_W'(TMR_11MS_CYC);
    endcase
    // page sticky
    // a page arriving during the clearing read wins over the clear
    page_d = page_q;
    if (rd_an)
      page_d = 1'b0;
    if (i_an_page_rx)
      page_d = 1'b1;
    done_d = i_an_complete;
    done_prev_d = done_q;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tsel_q <= `ESR_TIMER_RST;
      tcyc_q <= '0;
      page_q <= 1'b0;
      done_q <= 1'b0;
      done_prev_q <= 1'b0;
    end else begin
      tsel_q <= tsel_d;
      tcyc_q <= tcyc_d;
      page_q <= page_d;
      done_q <= done_d;
      done_prev_q <= done_prev_d;
    end
  end

  assign o_an_timer_sel = tsel_q;
  assign o_an_timer_cycles = tcyc_q;

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  logic [`ESR_IRQ_W-1:0] ist_q, ist_d;
  logic [`ESR_IRQ_W-1:0] imsk_q, imsk_d;
  logic [`ESR_IRQ_W-1:0] ev;
  logic irq_q, irq_d;

  always_comb begin
    ev = '0;
    ev[`ESR_IRQ_XMII] = esd_edge[0];
    ev[`ESR_IRQ_MDI] = esd_edge[1];
    ev[`ESR_IRQ_PAGE] = i_an_page_rx;
    ev[`ESR_IRQ_DONE] = done_q & ~done_prev_q;
    ist_d = ist_q;
    imsk_d = imsk_q;
    // write one to clear; a new event in the same cycle stays set
    if (i_bus.wr && hit_sts)
      ist_d = ist_q & ~i_bus.wdata[`ESR_IRQ_W-1:0];
    ist_d = ist_d | ev;
    if (i_bus.wr && hit_msk)
      imsk_d = i_bus.wdata[`ESR_IRQ_W-1:0];
    // irq lags status by one cycle, the price of a registered output
    irq_d = |(ist_q & imsk_q);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ist_q <= '0;
      imsk_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ist_q <= ist_d;
      imsk_q <= imsk_d;
      irq_q <= irq_d;
    end
  end

  assign o_irq = irq_q;

  // ------------------------------------------------------------
  // read data, valid only in the cycle after the strobe
  // ------------------------------------------------------------
  logic [`ESR_DATA_W-1:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = '0;
    if (i_bus.rd) begin
      if (hit_cnt) begin
        rdata_d[`ESR_XMII_CNT_LSB +: `ESR_CNT_W] = cnt_q[0];
        rdata_d[`ESR_MDI_CNT_LSB +: `ESR_CNT_W] = cnt_q[1];
      end else if (hit_sts) begin
        rdata_d[`ESR_IRQ_W-1:0] = ist_q;
      end else if (hit_msk) begin
        rdata_d[`ESR_IRQ_W-1:0] = imsk_q;
      end else if (hit_tmr) begin
        rdata_d[`ESR_TIMER_LSB +: 2] = tsel_q;
        rdata_d[`ESR_TIMER_LSB-1:0] = `ESR_TIMER_RSVD;
      end else if (hit_an) begin
        rdata_d[`ESR_PAGE_BIT] = page_q;
        rdata_d[`ESR_DONE_BIT] = done_q;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // mac-side count step
  property p_mac_count;
    @(posedge i_clk_sys) disable iff (i_power_on_reset)
      (esd_edge[0] && cnt_q[0] != CNT_MAX)
      |=> (cnt_q[0] == $past(cnt_q[0]) + `ESR_CNT_W'(1));
  endproperty
  a_mac_count: assert property (p_mac_count)
    else $error("mac-side counter missed an event");

  property p_line_count;
    @(posedge i_clk_sys) disable iff (i_power_on_reset)
      (esd_edge[1] && cnt_q[1] != CNT_MAX)
      |=> (cnt_q[1] == $past(cnt_q[1]) + `ESR_CNT_W'(1));
  endproperty
  a_line_count: assert property (p_line_count)
    else $error("line-side counter did not advance");

  // close detections both count
  // the quiet cycles between the edges keep a third edge out of the sum
  property p_no_deadtime;
    @(posedge i_clk_sys) disable iff (i_power_on_reset)
      (esd_edge[0] && cnt_q[0] < CNT_MAX - `ESR_CNT_W'(1))
      ##1 (!esd_edge[0]) [*4] ##1 esd_edge[0]
      |=> (cnt_q[0] == $past(cnt_q[0], 6) + `ESR_CNT_W'(2));
  endproperty
  a_no_deadtime: assert property (p_no_deadtime)
    else $error("second close detection was dropped");

  property p_hw_reset_keeps;
    @(posedge i_clk_sys) disable iff (i_power_on_reset)
      (i_reset && esd_edge == 2'b00) |=> $stable(cnt_q[0]) && $stable(cnt_q[1]);
  endproperty
  a_hw_reset_keeps: assert property (p_hw_reset_keeps)
    else $error("hardware reset disturbed esd counters");

  property p_timer_write;
    @(posedge i_clk_sys) disable iff (i_reset)
      (i_bus.wr && hit_tmr)
      |=> (o_an_timer_sel == $past(i_bus.wdata[`ESR_TIMER_LSB +: 2]))
      ##1 (o_an_timer_cycles != '0);
  endproperty
  a_timer_write: assert property (p_timer_write)
    else $error("timer select not updated");

  // default length decode
  // reset is tested in the antecedent since the length lags the select
  property p_timer_len;
    @(posedge i_clk_sys) disable iff (i_reset)
      (!i_reset && o_an_timer_sel == ESR_TMR_2US)
      |=> (o_an_timer_cycles == `ESR_TMR_W'(TMR_2US_CYC));
  endproperty
  a_timer_len: assert property (p_timer_len)
    else $error("short timer length wrong");

  property p_page_set;
    @(posedge i_clk_sys) disable iff (i_reset)
      (!i_reset && page_q && i_bus.rd && hit_an) |=> o_rdata[`ESR_PAGE_BIT];
  endproperty
  a_page_set: assert property (p_page_set)
    else $error("page bit not reported");

  property p_page_clear;
    @(posedge i_clk_sys) disable iff (i_reset)
      (!i_reset && i_bus.rd && hit_an && !i_an_page_rx) |=> !page_q;
  endproperty
  a_page_clear: assert property (p_page_clear)
    else $error("page bit not cleared by read");

  property p_done_read;
    @(posedge i_clk_sys) disable iff (i_reset)
      (done_q && i_bus.rd && hit_an)
      |=> o_rdata[`ESR_DONE_BIT] && !o_rdata[`ESR_DATA_W-1];
  endproperty
  a_done_read: assert property (p_done_read)
    else $error("complete bit not reported");

  property p_saturate;
    @(posedge i_clk_sys) disable iff (i_power_on_reset)
      (cnt_q[1] == CNT_MAX) |=> (cnt_q[1] == CNT_MAX) [*3];
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("line-side counter wrapped");

endmodule : esr_regs

// File: testbench/esr_an_partner.sv
// far-side negotiation model: page pulses and completion level
// assumes bench commands change just after a rising edge of i_clk_sys
`timescale 1ns/1ps

module esr_an_partner (
  // clock
  input logic i_clk_sys,
  // bench commands
  input logic i_send_page,
  input logic i_set_done,
  // negotiation signals toward the block
  output logic o_an_page_rx,
  output logic o_an_complete
);
  // a page is one clock wide, so a clearing read can be timed after it
  always_ff @(posedge i_clk_sys) begin
    o_an_page_rx <= i_send_page;
    o_an_complete <= i_set_done;
  end
endmodule : esr_an_partner

// File: testbench/esr_regs_bench.sv
// self-checking bench for the esd count and negotiation register bank
// assumes a 40 MHz clock and shortened negotiation timer parameters
`timescale 1ns/1ps
`include "esr_consts.svh"

module esr_regs_bench;
  import esr_pkg::*;
  localparam int C16 = 100;
  localparam int C800 = 50;
  localparam int C11 = 200;
  logic i_clk_sys, i_reset, i_por, i_mac, i_line, send_page, set_done;
  logic page_rx, an_done, o_irq;
  esr_bus_req_s i_bus;
  logic [15:0] o_rdata;
  logic [1:0] o_sel;
  logic [18:0] o_cyc;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int tmr [4] = '{C16, 80, C800, C11};

  esr_regs #(.TMR_1P6MS_CYC(C16), .TMR_800US_CYC(C800), .TMR_11MS_CYC(C11)) dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_power_on_reset(i_por),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_esd_mac_side(i_mac),
    .i_esd_line_side(i_line), .i_an_page_rx(page_rx), .i_an_complete(an_done),
    .o_an_timer_sel(o_sel), .o_an_timer_cycles(o_cyc), .o_irq(o_irq));
  esr_an_partner partner (.i_clk_sys(i_clk_sys), .i_send_page(send_page),
    .i_set_done(set_done), .o_an_page_rx(page_rx), .o_an_complete(an_done));

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  // free-running 25 ns clock
  initial begin
    i_clk_sys = 0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // whole run needs about 500 cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [18:0] got, input logic [18:0] exp, input string w);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : settle
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge i_clk_sys) i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk_sys) i_bus <= '0;
  endtask : wr
  // read data is only valid in the single cycle after the strobe
  task automatic rchk(input logic [10:0] a, input logic [15:0] e, input string w);
    @(posedge i_clk_sys) i_bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge i_clk_sys) i_bus <= '0;
    #1 chk(19'(o_rdata), 19'(e), w);
  endtask : rchk
  // m and l pulses, two cycles high and three low, like a bouncing discharge
  task automatic zap(input int m, input int l);
    for (int i = 0; i < m || i < l; i++) begin
      @(posedge i_clk_sys) begin
        i_mac <= (i < m);
        i_line <= (i < l);
      end
      repeat (2) @(posedge i_clk_sys);
      i_mac <= 0;
      i_line <= 0;
      repeat (2) @(posedge i_clk_sys);
    end
    settle(4);
  endtask : zap
  task automatic pulse_page;
    @(posedge i_clk_sys) send_page <= 1;
    @(posedge i_clk_sys) send_page <= 0;
    settle(3);
  endtask : pulse_page

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(19'(o_sel), 19'h1, "sel");
    chk(o_cyc, 19'd80, "cycles");
    rchk(`ESR_OFF_TIMER_CFG, 16'h1008, "timer");
    rchk(11'h400, 16'h0, "unmapped");
    rchk(`ESR_OFF_AN_STATUS, 16'h0, "status");
    rchk(`ESR_OFF_ESD_COUNTS, 16'h0, "esd");
    $display("test reset done");
  endtask : t_reset
  task automatic t_timer;
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      wr(`ESR_OFF_TIMER_CFG, {2'b11, s, 12'hFFF});
      settle(1);
      chk(o_cyc, 19'(tmr[i]), "cycles");
      rchk(`ESR_OFF_TIMER_CFG, {2'b00, s, 12'h008}, "timer");
    end
    $display("test timer done");
  endtask : t_timer
  task automatic t_esd;
    zap(3, 2);
    rchk(`ESR_OFF_ESD_COUNTS, 16'h0302, "esd");
    wr(`ESR_OFF_ESD_COUNTS, 16'hFFFF);
    zap(2, 0);
    rchk(`ESR_OFF_ESD_COUNTS, 16'h0502, "bounce");
    zap(70, 70);
    rchk(`ESR_OFF_ESD_COUNTS, 16'h3F3F, "sat");
    @(posedge i_clk_sys) i_reset <= 1;
    settle(2);
    @(posedge i_clk_sys) i_reset <= 0;
    rchk(`ESR_OFF_ESD_COUNTS, 16'h3F3F, "hwrst");
    @(posedge i_clk_sys) i_por <= 1;
    @(posedge i_clk_sys) i_por <= 0;
    rchk(`ESR_OFF_ESD_COUNTS, 16'h0, "por");
    $display("test esd done");
  endtask : t_esd
  task automatic t_an;
    pulse_page();
    rchk(`ESR_OFF_AN_STATUS, 16'h2, "page");
    rchk(`ESR_OFF_AN_STATUS, 16'h0, "page gone");
    @(posedge i_clk_sys) set_done <= 1;
    settle(3);
    rchk(`ESR_OFF_AN_STATUS, 16'h1, "done");
    @(posedge i_clk_sys) set_done <= 0;
    settle(3);
    rchk(`ESR_OFF_AN_STATUS, 16'h0, "undone");
    $display("test negotiation done");
  endtask : t_an
  task automatic t_irq;
    wr(`ESR_OFF_IRQ_STATUS, 16'hF);
    pulse_page();
    chk(19'(o_irq), 19'h0, "masked");
    rchk(`ESR_OFF_IRQ_STATUS, 16'h4, "irq status");
    wr(`ESR_OFF_IRQ_MASK, 16'h4);
    settle(2);
    chk(19'(o_irq), 19'h1, "irq");
    wr(`ESR_OFF_IRQ_STATUS, 16'h4);
    settle(2);
    chk(19'(o_irq), 19'h0, "cleared");
    rchk(`ESR_OFF_IRQ_MASK, 16'h4, "mask");
    // esd edges and a completion rise latch their own status bits
    zap(1, 1);
    @(posedge i_clk_sys) set_done <= 1;
    settle(4);
    rchk(`ESR_OFF_IRQ_STATUS, 16'hB, "events");
    chk(19'(o_irq), 19'h0, "other masked");
    $display("test irq done");
  endtask : t_irq

  // ----------------------------------------
  // main sequence and verdict
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // both resets held for ten cycles, counters start cleared
  initial begin
    i_reset = 1;
    i_por = 1;
    i_bus = '0;
    i_mac = 0;
    i_line = 0;
    send_page = 0;
    set_done = 0;
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 0;
    i_por <= 0;
    settle(2);
    t_reset();
    t_timer();
    t_esd();
    t_an();
    t_irq();
    conclude();
  end
endmodule : esr_regs_bench
